// file: inc/dpg_pkg.sv
// Package: register map, reset values and widths of the dual GPIO port block
package dpg_pkg;
  localparam int unsigned DPG_ADDR_W = 8;
  localparam int unsigned DPG_PORT_W = 8;

  // Register addresses
  localparam logic [7:0] DPG_ADDR_P0_DATA  = 8'h80;
  localparam logic [7:0] DPG_ADDR_P1_DATA  = 8'h90;
  localparam logic [7:0] DPG_ADDR_P0_OMODE = 8'ha4;
  localparam logic [7:0] DPG_ADDR_P1_OMODE = 8'ha5;
  localparam logic [7:0] DPG_ADDR_P1_MATCH = 8'hcf;
  localparam logic [7:0] DPG_ADDR_P0_MASK  = 8'hc7;
  localparam logic [7:0] DPG_ADDR_P0_SKIP  = 8'hd4;
  localparam logic [7:0] DPG_ADDR_P1_SKIP  = 8'hd5;
  localparam logic [7:0] DPG_ADDR_P0_MATCH = 8'hd7;
  localparam logic [7:0] DPG_ADDR_P1_MASK  = 8'hbe;
  localparam logic [7:0] DPG_ADDR_P0_IMODE = 8'hf1;
  localparam logic [7:0] DPG_ADDR_P1_IMODE = 8'hf2;

  // Reset values
  localparam logic [7:0] DPG_RST_P0_DATA  = 8'hff;
  localparam logic [7:0] DPG_RST_P1_DATA  = 8'hff;
  localparam logic [7:0] DPG_RST_OMODE    = 8'h00;
  localparam logic [7:0] DPG_RST_MASK     = 8'h00;
  localparam logic [7:0] DPG_RST_SKIP     = 8'h00;
  localparam logic [7:0] DPG_RST_MATCH    = 8'hff;
  localparam logic [7:0] DPG_RST_IMODE    = 8'hff;
  localparam logic [7:0] DPG_RST_ZERO     = 8'h00;

  // Match output stages: sync (2) then registered compare
  localparam int unsigned DPG_SYNC_STAGES = 2;
endpackage : dpg_pkg

// file: hdl/dpg_pin_cell.sv
// Per-port pin driver cell: drive enables, pullups and two-stage input sync
`timescale 1ns/1ps
module dpg_pin_cell
  import dpg_pkg::*;
#(
  parameter int unsigned WIDTH = dpg_pkg::DPG_PORT_W
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] latch,
  input  wire logic [WIDTH-1:0] input_mode,
  input  wire logic [WIDTH-1:0] output_mode,
  input  wire logic [WIDTH-1:0] force_od,
  input  wire logic             crossbar_enable_bit,
  input  wire logic             weak_pullup_disable,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic      [WIDTH-1:0] pullup_en,
  output logic      [WIDTH-1:0] pin_sync
);
  import dpg_pkg::*;

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] oe_reg;
  logic [WIDTH-1:0] pu_reg;
  logic [WIDTH-1:0] out_next;
  logic [WIDTH-1:0] oe_next;
  logic [WIDTH-1:0] pu_next;
  logic [WIDTH-1:0] pushpull;

  // The owning port registers are one byte wide
  if (WIDTH < 1 || WIDTH > 8) begin : g_width_check
    $error("dpg_pin_cell: WIDTH must be 1..8");
  end

  // Drive decision per pin; low driven on digital pins while the crossbar is on, high only in push-pull
  always_comb begin
    pushpull = output_mode & ~force_od & input_mode;          // [RULE9] [RULE10]
    out_next = latch;                                         // [RULE3]
    oe_next  = {WIDTH{crossbar_enable_bit}} & input_mode &    // [RULE17] [RULE8]
               (~latch | pushpull);                           // [RULE6]
    // Pullup only on open-drain digital pins not pulling low
    pu_next  = {WIDTH{~weak_pullup_disable}} & input_mode &   // [RULE18]
               ~pushpull & ~(oe_next & ~latch);               // [RULE18]
  end

  // Register outputs; the first sync stage feeds only the second
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      sync_reg <= '0;
      out_reg  <= '0;
      oe_reg   <= '0;
      pu_reg   <= '0;
    end else begin
      meta_reg <= pin_in;                                     // [RULE19]
      sync_reg <= meta_reg;                                   // [RULE19]
      out_reg  <= out_next;
      oe_reg   <= oe_next;
      pu_reg   <= pu_next;
    end
  end

  assign pin_out   = out_reg;
  assign pin_oe    = oe_reg;
  assign pullup_en = pu_reg;
  assign pin_sync  = sync_reg;
endmodule : dpg_pin_cell

// file: hdl/dpg_gpio.sv
// Dual 8-bit GPIO port: latches, readback, modes, skip bits and port match
//
// Contract
// RULE1 - Unassigned digital pins usable as software GPIO
// RULE2 - Data registers byte and bit accessible
// RULE3 - Written latch value keeps driving pins
// RULE4 - Normal read returns pin levels always
// RULE5 - Read-modify-write reads latch not pins
// RULE6 - Latch 0 drives low; 1 high or float
// RULE7 - Analog pin reads back as zero
// RULE8 - Input mode 0 is analog, disables digital
// RULE9 - Output mode 0 open-drain, 1 push-pull
// RULE10 - Serial bus pins always open-drain
// RULE11 - Skip bit 1 makes crossbar pass pin
// RULE12 - Software skips analog and special pins
// RULE13 - Masked mismatch on either port raises match
// RULE14 - Mask 0 excludes pin from compare
// RULE15 - Match uses pin levels regardless of routing
// RULE16 - Match requests interrupt if enabled, wakes oscillator
// RULE17 - Drivers disabled while crossbar is disabled
// RULE18 - Pullup off when driving low or analog
// RULE19 - Pin inputs pass two sync flip-flops
`timescale 1ns/1ps
module dpg_gpio
  import dpg_pkg::*;
#(
  parameter int unsigned WIDTH = dpg_pkg::DPG_PORT_W
) (
  input  wire logic                               clock,
  input  wire logic                               reset,
  input  wire logic [dpg_pkg::DPG_ADDR_W-1:0]     sfr_addr,
  input  wire logic [7:0]                         sfr_wdata,
  input  wire logic                               sfr_wr,
  input  wire logic                               sfr_rd,
  input  wire logic                               sfr_rmw,
  input  wire logic                               sfr_bit,
  input  wire logic [2:0]                         sfr_bit_sel,
  output logic      [7:0]                         sfr_rdata,
  input  wire logic                               crossbar_enable_bit,
  input  wire logic                               weak_pullup_disable,
  input  wire logic                               match_irq_enable,
  input  wire logic [WIDTH-1:0]                   p0_serial_od,
  input  wire logic [WIDTH-1:0]                   p1_serial_od,
  input  wire logic [WIDTH-1:0]                   p0_pin_in,
  input  wire logic [WIDTH-1:0]                   p1_pin_in,
  output logic      [WIDTH-1:0]                   p0_pin_out,
  output logic      [WIDTH-1:0]                   p0_pin_oe,
  output logic      [WIDTH-1:0]                   p0_pullup_en,
  output logic      [WIDTH-1:0]                   p1_pin_out,
  output logic      [WIDTH-1:0]                   p1_pin_oe,
  output logic      [WIDTH-1:0]                   p1_pullup_en,
  output logic      [WIDTH-1:0]                   port_zero_crossbar_skip,
  output logic      [WIDTH-1:0]                   port_one_crossbar_skip,
  output logic                                    port_match,
  output logic                                    match_irq,
  output logic                                    osc_wake
);
  import dpg_pkg::*;

  // Byte-wide registers and the bit merge cannot serve another port width
  if (WIDTH != 8) begin : g_width_check
    $error("dpg_gpio: WIDTH must be 8 for byte registers");
  end

  // The pin cells carry exactly two synchroniser flip-flops
  if (DPG_SYNC_STAGES != 2) begin : g_sync_check
    $error("dpg_gpio: only two sync stages are built");
  end

  // Register selector; unmapped addresses fall to NONE so writes vanish and reads give zero
  typedef enum logic [3:0] {
    DPG_R_NONE, DPG_R_P0, DPG_R_P1, DPG_R_P0_OM, DPG_R_P1_OM, DPG_R_P0_MK, DPG_R_P1_MK,
    DPG_R_P0_SK, DPG_R_P1_SK, DPG_R_P0_MT, DPG_R_P1_MT, DPG_R_P0_IM, DPG_R_P1_IM
  } dpg_reg_e;

  // Address decode shared by read and write paths
  function automatic dpg_reg_e dpg_decode(input logic [7:0] a);
    case (a)
      DPG_ADDR_P0_DATA:  dpg_decode = DPG_R_P0;
      DPG_ADDR_P1_DATA:  dpg_decode = DPG_R_P1;
      DPG_ADDR_P0_OMODE: dpg_decode = DPG_R_P0_OM;
      DPG_ADDR_P1_OMODE: dpg_decode = DPG_R_P1_OM;
      DPG_ADDR_P0_MASK:  dpg_decode = DPG_R_P0_MK;
      DPG_ADDR_P1_MASK:  dpg_decode = DPG_R_P1_MK;
      DPG_ADDR_P0_SKIP:  dpg_decode = DPG_R_P0_SK;
      DPG_ADDR_P1_SKIP:  dpg_decode = DPG_R_P1_SK;
      DPG_ADDR_P0_MATCH: dpg_decode = DPG_R_P0_MT;
      DPG_ADDR_P1_MATCH: dpg_decode = DPG_R_P1_MT;
      DPG_ADDR_P0_IMODE: dpg_decode = DPG_R_P0_IM;
      DPG_ADDR_P1_IMODE: dpg_decode = DPG_R_P1_IM;
      default:           dpg_decode = DPG_R_NONE;
    endcase
  endfunction : dpg_decode

  // Merge a byte or single-bit write into the old register value
  // Every register takes bit writes; only the data ports need them, elsewhere harmless
  function automatic logic [7:0] dpg_merge(input logic [7:0] old, input logic [7:0] wd,
                                           input logic is_bit, input logic [2:0] sel);
    logic [7:0] r;
    r = old;
    if (is_bit) begin
      r[sel] = wd[0];
    end else begin
      r = wd;
    end
    dpg_merge = r;
  endfunction : dpg_merge

  // Masked pattern mismatch on one port
  function automatic logic dpg_mismatch(input logic [7:0] pins, input logic [7:0] val,
                                        input logic [7:0] mask);
    dpg_mismatch = ((pins & mask) != (val & mask));
  endfunction : dpg_mismatch

  logic [7:0] p0_data_reg;
  logic [7:0] p0_data_next;
  logic [7:0] p1_data_reg;
  logic [7:0] p1_data_next;
  logic [7:0] p0_om_reg;
  logic [7:0] p0_om_next;
  logic [7:0] p1_om_reg;
  logic [7:0] p1_om_next;
  logic [7:0] p0_mk_reg;
  logic [7:0] p0_mk_next;
  logic [7:0] p1_mk_reg;
  logic [7:0] p1_mk_next;
  logic [7:0] p0_sk_reg;
  logic [7:0] p0_sk_next;
  logic [7:0] p1_sk_reg;
  logic [7:0] p1_sk_next;
  logic [7:0] p0_mt_reg;
  logic [7:0] p0_mt_next;
  logic [7:0] p1_mt_reg;
  logic [7:0] p1_mt_next;
  logic [7:0] p0_im_reg;
  logic [7:0] p0_im_next;
  logic [7:0] p1_im_reg;
  logic [7:0] p1_im_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       match_reg;
  logic       match_next;
  logic       irq_reg;
  logic       irq_next;
  logic       wake_reg;
  logic       wake_next;
  logic       p0_miss;
  logic       p1_miss;
  logic [7:0] p0_sync;
  logic [7:0] p1_sync;
  logic [7:0] p0_view;
  logic [7:0] p1_view;
  dpg_reg_e   sel;

  // Register writes; the core's read-modify-write supplies its latch-based result here
  always_comb begin
    sel          = dpg_decode(sfr_addr);
    p0_data_next = p0_data_reg;
    p1_data_next = p1_data_reg;
    p0_om_next   = p0_om_reg;
    p1_om_next   = p1_om_reg;
    p0_mk_next   = p0_mk_reg;
    p1_mk_next   = p1_mk_reg;
    p0_sk_next   = p0_sk_reg;
    p1_sk_next   = p1_sk_reg;
    p0_mt_next   = p0_mt_reg;
    p1_mt_next   = p1_mt_reg;
    p0_im_next   = p0_im_reg;
    p1_im_next   = p1_im_reg;
    if (sfr_wr) begin
      case (sel)
        DPG_R_P0:    p0_data_next = dpg_merge(p0_data_reg, sfr_wdata, sfr_bit, sfr_bit_sel); // [RULE2] [RULE3]
        DPG_R_P1:    p1_data_next = dpg_merge(p1_data_reg, sfr_wdata, sfr_bit, sfr_bit_sel); // [RULE2] [RULE3]
        DPG_R_P0_OM: p0_om_next   = dpg_merge(p0_om_reg, sfr_wdata, sfr_bit, sfr_bit_sel);
        DPG_R_P1_OM: p1_om_next   = dpg_merge(p1_om_reg, sfr_wdata, sfr_bit, sfr_bit_sel);
        DPG_R_P0_MK: p0_mk_next   = dpg_merge(p0_mk_reg, sfr_wdata, sfr_bit, sfr_bit_sel);
        DPG_R_P1_MK: p1_mk_next   = dpg_merge(p1_mk_reg, sfr_wdata, sfr_bit, sfr_bit_sel);
        DPG_R_P0_SK: p0_sk_next   = dpg_merge(p0_sk_reg, sfr_wdata, sfr_bit, sfr_bit_sel); // [RULE11]
        DPG_R_P1_SK: p1_sk_next   = dpg_merge(p1_sk_reg, sfr_wdata, sfr_bit, sfr_bit_sel); // [RULE11]
        DPG_R_P0_MT: p0_mt_next   = dpg_merge(p0_mt_reg, sfr_wdata, sfr_bit, sfr_bit_sel);
        DPG_R_P1_MT: p1_mt_next   = dpg_merge(p1_mt_reg, sfr_wdata, sfr_bit, sfr_bit_sel);
        DPG_R_P0_IM: p0_im_next   = dpg_merge(p0_im_reg, sfr_wdata, sfr_bit, sfr_bit_sel);
        DPG_R_P1_IM: p1_im_next   = dpg_merge(p1_im_reg, sfr_wdata, sfr_bit, sfr_bit_sel);
        default: ;
      endcase
    end
  end

  // Digital view of the pins: analog pins read as zero
  assign p0_view = p0_sync & p0_im_reg;                   // [RULE7] [RULE8]
  assign p1_view = p1_sync & p1_im_reg;                   // [RULE7] [RULE8]

  // Read mux: pins on a plain read, latch on read-modify-write
  // A read and a write in one cycle return the value from before the write
  always_comb begin
    rdata_next = 8'h00;
    if (sfr_rd) begin
      case (dpg_decode(sfr_addr))
        DPG_R_P0:    rdata_next = sfr_rmw ? p0_data_reg : p0_view;  // [RULE4] [RULE5] [RULE1]
        DPG_R_P1:    rdata_next = sfr_rmw ? p1_data_reg : p1_view;  // [RULE4] [RULE5] [RULE1]
        DPG_R_P0_OM: rdata_next = p0_om_reg;
        DPG_R_P1_OM: rdata_next = p1_om_reg;
        DPG_R_P0_MK: rdata_next = p0_mk_reg;
        DPG_R_P1_MK: rdata_next = p1_mk_reg;
        DPG_R_P0_SK: rdata_next = p0_sk_reg;
        DPG_R_P1_SK: rdata_next = p1_sk_reg;
        DPG_R_P0_MT: rdata_next = p0_mt_reg;
        DPG_R_P1_MT: rdata_next = p1_mt_reg;
        DPG_R_P0_IM: rdata_next = p0_im_reg;
        DPG_R_P1_IM: rdata_next = p1_im_reg;
        default:     rdata_next = 8'h00;
      endcase
    end
  end

  // Match is a level; it follows pins until the pattern matches again
  always_comb begin
    p0_miss    = dpg_mismatch(p0_view, p0_mt_reg, p0_mk_reg);      // [RULE13] [RULE14] [RULE15]
    p1_miss    = dpg_mismatch(p1_view, p1_mt_reg, p1_mk_reg);      // [RULE13] [RULE14] [RULE15]
    match_next = p0_miss | p1_miss;                                // [RULE13]
    irq_next   = match_next & match_irq_enable;                    // [RULE16]
    wake_next  = match_next;                                       // [RULE16]
  end

  // State registers
  // Reset values come from the package so every user of the map agrees
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      p0_data_reg <= DPG_RST_P0_DATA;
      p1_data_reg <= DPG_RST_P1_DATA;
      p0_om_reg   <= DPG_RST_OMODE;
      p1_om_reg   <= DPG_RST_OMODE;
      p0_mk_reg   <= DPG_RST_MASK;
      p1_mk_reg   <= DPG_RST_MASK;
      p0_sk_reg   <= DPG_RST_SKIP;
      p1_sk_reg   <= DPG_RST_SKIP;
      p0_mt_reg   <= DPG_RST_MATCH;
      p1_mt_reg   <= DPG_RST_MATCH;
      p0_im_reg   <= DPG_RST_IMODE;
      p1_im_reg   <= DPG_RST_IMODE;
      rdata_reg   <= DPG_RST_ZERO;
      match_reg   <= 1'b0;
      irq_reg     <= 1'b0;
      wake_reg    <= 1'b0;
    end else begin
      p0_data_reg <= p0_data_next;
      p1_data_reg <= p1_data_next;
      p0_om_reg   <= p0_om_next;
      p1_om_reg   <= p1_om_next;
      p0_mk_reg   <= p0_mk_next;
      p1_mk_reg   <= p1_mk_next;
      p0_sk_reg   <= p0_sk_next;
      p1_sk_reg   <= p1_sk_next;
      p0_mt_reg   <= p0_mt_next;
      p1_mt_reg   <= p1_mt_next;
      p0_im_reg   <= p0_im_next;
      p1_im_reg   <= p1_im_next;
      rdata_reg   <= rdata_next;
      match_reg   <= match_next;
      irq_reg     <= irq_next;
      wake_reg    <= wake_next;
    end
  end

  // Pin cells; outputs lag register writes by one cycle
  // Crossbar enable and pullup disable are global, so both ports share them
  dpg_pin_cell #(.WIDTH(WIDTH)) u_port0 (
    .clock               (clock),
    .reset               (reset),
    .latch               (p0_data_reg),
    .input_mode          (p0_im_reg),
    .output_mode         (p0_om_reg),
    .force_od            (p0_serial_od),                   // [RULE10]
    .crossbar_enable_bit (crossbar_enable_bit),            // [RULE17]
    .weak_pullup_disable (weak_pullup_disable),
    .pin_in              (p0_pin_in),
    .pin_out             (p0_pin_out),
    .pin_oe              (p0_pin_oe),
    .pullup_en           (p0_pullup_en),
    .pin_sync            (p0_sync)                         // [RULE19]
  );

  dpg_pin_cell #(.WIDTH(WIDTH)) u_port1 (
    .clock               (clock),
    .reset               (reset),
    .latch               (p1_data_reg),
    .input_mode          (p1_im_reg),
    .output_mode         (p1_om_reg),
    .force_od            (p1_serial_od),                   // [RULE10]
    .crossbar_enable_bit (crossbar_enable_bit),            // [RULE17]
    .weak_pullup_disable (weak_pullup_disable),
    .pin_in              (p1_pin_in),
    .pin_out             (p1_pin_out),
    .pin_oe              (p1_pin_oe),
    .pullup_en           (p1_pullup_en),
    .pin_sync            (p1_sync)                         // [RULE19]
  );

  // Outputs straight from flip-flops
  assign sfr_rdata               = rdata_reg;
  assign port_zero_crossbar_skip = p0_sk_reg;              // [RULE11]
  assign port_one_crossbar_skip  = p1_sk_reg;
  assign port_match              = match_reg;
  assign match_irq               = irq_reg;
  assign osc_wake                = wake_reg;
endmodule : dpg_gpio

// file: verification/dpg_gpio_chk.sv
// Checker: port-level assertions for the dual GPIO block
`timescale 1ns/1ps
module dpg_gpio_chk
  import dpg_pkg::*;
#(
  parameter int unsigned WIDTH = dpg_pkg::DPG_PORT_W
) (
  input wire logic                           clock,
  input wire logic                           reset,
  input wire logic [dpg_pkg::DPG_ADDR_W-1:0] sfr_addr,
  input wire logic [7:0]                     sfr_wdata,
  input wire logic                           sfr_wr,
  input wire logic                           sfr_bit,
  input wire logic                           crossbar_enable_bit,
  input wire logic                           weak_pullup_disable,
  input wire logic                           match_irq_enable,
  input wire logic [WIDTH-1:0]               p0_serial_od,
  input wire logic [WIDTH-1:0]               p1_serial_od,
  input wire logic [WIDTH-1:0]               p0_pin_in,
  input wire logic [WIDTH-1:0]               p1_pin_in,
  input wire logic [WIDTH-1:0]               p0_pin_out,
  input wire logic [WIDTH-1:0]               p0_pin_oe,
  input wire logic [WIDTH-1:0]               p0_pullup_en,
  input wire logic [WIDTH-1:0]               p1_pin_out,
  input wire logic [WIDTH-1:0]               p1_pin_oe,
  input wire logic [WIDTH-1:0]               p1_pullup_en,
  input wire logic                           port_match,
  input wire logic                           match_irq,
  input wire logic                           osc_wake
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Byte write to port zero data that no later write overrides at once
  sequence s_p0_write;
    sfr_wr && !sfr_bit && sfr_addr == DPG_ADDR_P0_DATA ##1 !(sfr_wr && sfr_addr == DPG_ADDR_P0_DATA);
  endsequence
  // Long enough quiet spell for sync stages and the compare to settle
  sequence s_quiet;
    (!sfr_wr && $stable(p0_pin_in) && $stable(p1_pin_in)) [*4];
  endsequence
  // Drivers, pullups and the match path
  a_oe_needs_xbar: assert property (
    !crossbar_enable_bit |=> p0_pin_oe == '0 && p1_pin_oe == '0) else $error("driver on while crossbar off");
  a_serial_od: assert property (
    (p0_pin_oe & p0_pin_out & $past(p0_serial_od)) == '0 && (p1_pin_oe & p1_pin_out & $past(p1_serial_od)) == '0)
    else $error("serial pin driven high");
  a_pull_low_off: assert property (
    (p0_pullup_en & p0_pin_oe & ~p0_pin_out) == '0 && (p1_pullup_en & p1_pin_oe & ~p1_pin_out) == '0)
    else $error("pullup on while driving low");
  a_wpud_off: assert property (
    weak_pullup_disable |=> p0_pullup_en == '0 && p1_pullup_en == '0) else $error("pullup on while disabled");
  a_irq_gate: assert property (
    match_irq == (port_match && $past(match_irq_enable))) else $error("match request not gated by enable");
  a_wake_match: assert property (
    osc_wake == port_match) else $error("wake differs from match");
  a_byte_write: assert property (
    s_p0_write |=> p0_pin_out == $past(sfr_wdata, 2)) else $error("written byte not on pins");
  a_quiet_match: assert property (
    s_quiet |-> $stable(port_match)) else $error("match moved without cause");
endmodule : dpg_gpio_chk

bind dpg_gpio dpg_gpio_chk #(.WIDTH(WIDTH)) u_chk (.clock, .reset, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_bit,
  .crossbar_enable_bit, .weak_pullup_disable, .match_irq_enable, .p0_serial_od, .p1_serial_od, .p0_pin_in,
  .p1_pin_in, .p0_pin_out, .p0_pin_oe, .p0_pullup_en, .p1_pin_out, .p1_pin_oe, .p1_pullup_en, .port_match,
  .match_irq, .osc_wake);

// file: verification/dpg_pin_model.sv
// Partner: outside circuitry on one eight-pin port
`timescale 1ns/1ps
module dpg_pin_model (
  input  wire logic       clock,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_level
);
  logic tgl_reg;
  // Floating pins wander every cycle so a stale level is never read back
  always_ff @(posedge clock) tgl_reg <= (tgl_reg === 1'b1) ? 1'b0 : 1'b1;
  // Device driver first, then outside drive, then weak pullup
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : (pullup_en[i] | tgl_reg);
    end
  end
endmodule : dpg_pin_model

// file: verification/dpg_gpio_tb.sv
// Testbench: self-checking scenarios for the dual GPIO block
`timescale 1ns/1ps
module dpg_gpio_tb;
  import dpg_pkg::*;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic       sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0, sfr_bit = 1'b0;
  logic [2:0] sfr_bit_sel = 3'h0;
  logic       crossbar_enable_bit = 1'b0, weak_pullup_disable = 1'b0, match_irq_enable = 1'b0;
  logic [7:0] p0_serial_od = 8'h00, p1_serial_od = 8'h00;
  logic [7:0] ext0_en = 8'hff, ext0_val = 8'h00, ext1_en = 8'hff, ext1_val = 8'hff;
  logic [7:0] p0_pin_in, p0_pin_out, p0_pin_oe, p0_pullup_en, port_zero_crossbar_skip;
  logic [7:0] p1_pin_in, p1_pin_out, p1_pin_oe, p1_pullup_en, port_one_crossbar_skip;
  logic       port_match, match_irq, osc_wake;
  int         n_fail = 0;
  int         num_checks = 0;

  // 100 ns clock
  always #50 clock = ~clock;

  dpg_gpio u_dut (.clock, .reset, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rmw, .sfr_bit, .sfr_bit_sel,
    .sfr_rdata, .crossbar_enable_bit, .weak_pullup_disable, .match_irq_enable, .p0_serial_od, .p1_serial_od,
    .p0_pin_in, .p1_pin_in, .p0_pin_out, .p0_pin_oe, .p0_pullup_en, .p1_pin_out, .p1_pin_oe, .p1_pullup_en,
    .port_zero_crossbar_skip, .port_one_crossbar_skip, .port_match, .match_irq, .osc_wake);
  dpg_pin_model u_pins0 (.clock, .pin_out(p0_pin_out), .pin_oe(p0_pin_oe), .pullup_en(p0_pullup_en),
    .ext_en(ext0_en), .ext_val(ext0_val), .pin_level(p0_pin_in));
  dpg_pin_model u_pins1 (.clock, .pin_out(p1_pin_out), .pin_oe(p1_pin_oe), .pullup_en(p1_pullup_en),
    .ext_en(ext1_en), .ext_val(ext1_val), .pin_level(p1_pin_in));

  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    num_checks++;
    if (got !== want) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, want);
    end
  endtask : chk

  // One-cycle write strobe; bit mode writes sfr_wdata[0] to bit s
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0, input logic [2:0] s = 3'h0);
    @(posedge clock);
    sfr_addr    <= a;
    sfr_wdata   <= d;
    sfr_bit     <= b;
    sfr_bit_sel <= s;
    sfr_wr      <= 1'b1;
    @(posedge clock);
    sfr_wr      <= 1'b0;
    sfr_bit     <= 1'b0;
  endtask : wr

  // Read strobe; data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] want);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rmw  <= m;
    sfr_rd   <= 1'b1;
    @(posedge clock);
    sfr_rd   <= 1'b0;
    sfr_rmw  <= 1'b0;
    #1;
    chk(sfr_rdata, want);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle

  function automatic logic [7:0] ev();
    return {5'h00, port_match, match_irq, osc_wake};
  endfunction : ev

  task automatic t_reset_vals();
    logic [7:0] adr [13] = '{DPG_ADDR_P0_DATA, DPG_ADDR_P1_DATA, DPG_ADDR_P0_OMODE, DPG_ADDR_P1_OMODE,
      DPG_ADDR_P0_MASK, DPG_ADDR_P0_SKIP, DPG_ADDR_P1_SKIP, DPG_ADDR_P0_MATCH, DPG_ADDR_P0_IMODE,
      DPG_ADDR_P1_IMODE, DPG_ADDR_P1_MASK, DPG_ADDR_P1_MATCH, 8'h00};
    logic [7:0] rv [13] = '{DPG_RST_P0_DATA, DPG_RST_P1_DATA, DPG_RST_OMODE, DPG_RST_OMODE, DPG_RST_MASK,
      DPG_RST_SKIP, DPG_RST_SKIP, DPG_RST_MATCH, DPG_RST_IMODE, DPG_RST_IMODE, DPG_RST_MASK, DPG_RST_MATCH, 8'h00};
    // Latch view of every register, the unmapped address last
    for (int i = 0; i < 13; i++) begin
      rd(adr[i], 1'b1, rv[i]);
    end
    chk(port_zero_crossbar_skip, DPG_RST_SKIP);
  endtask : t_reset_vals

  task automatic t_match();
    settle(4);
    chk(ev(), 8'h00);
    wr(DPG_ADDR_P0_MASK, 8'h01);
    settle(4);
    chk(ev(), 8'h05);
    @(posedge clock);
    match_irq_enable <= 1'b1;
    settle(2);
    chk(ev(), 8'h07);
    ext0_val <= 8'h01;
    settle(2);
    chk(ev(), 8'h07);
    settle(2);
    chk(ev(), 8'h00);
    ext0_val <= 8'h03;
    settle(4);
    chk(ev(), 8'h00);
    wr(DPG_ADDR_P1_MASK, 8'h80);
    wr(DPG_ADDR_P1_MATCH, 8'h00);
    settle(4);
    chk(ev(), 8'h07);
    wr(DPG_ADDR_P1_MATCH, 8'h80);
    settle(4);
    chk(ev(), 8'h00);
  endtask : t_match

  task automatic t_drive();
    ext0_en <= 8'h04;
    ext0_val <= 8'h00;
    wr(DPG_ADDR_P0_DATA, 8'h0f);
    wr(DPG_ADDR_P0_OMODE, 8'h03);
    settle(3);
    chk(p0_pin_oe, 8'h00);
    @(posedge clock);
    crossbar_enable_bit <= 1'b1;
    settle(3);
    chk(p0_pin_out, 8'h0f);
    chk(p0_pin_oe, 8'hf3);
    chk(p0_pullup_en, 8'h0c);
    rd(DPG_ADDR_P0_DATA, 1'b0, 8'h0b);
    rd(DPG_ADDR_P0_DATA, 1'b1, 8'h0f);
    @(posedge clock);
    p0_serial_od <= 8'h01;
    settle(3);
    chk(p0_pin_oe, 8'hf2);
    chk(p0_pullup_en, 8'h0d);
  endtask : t_drive

  task automatic t_analog();
    ext1_en <= 8'hf0;
    wr(DPG_ADDR_P1_IMODE, 8'h0f);
    wr(DPG_ADDR_P1_SKIP, 8'hf0);
    wr(DPG_ADDR_P1_OMODE, 8'h0e);
    wr(DPG_ADDR_P1_DATA, 8'h55);
    settle(3);
    chk(port_one_crossbar_skip, 8'hf0);
    chk(p1_pin_oe, 8'h0e);
    chk(p1_pullup_en, 8'h01);
    rd(DPG_ADDR_P1_DATA, 1'b0, 8'h05);
    @(posedge clock);
    weak_pullup_disable <= 1'b1;
    settle(3);
    chk(p1_pullup_en | p0_pullup_en, 8'h00);
  endtask : t_analog

  task automatic t_bits();
    wr(DPG_ADDR_P1_DATA, 8'h01, 1'b1, 3'h7);
    rd(DPG_ADDR_P1_DATA, 1'b1, 8'hd5);
    wr(DPG_ADDR_P1_DATA, 8'h00, 1'b1, 3'h0);
    rd(DPG_ADDR_P1_DATA, 1'b1, 8'hd4);
    settle(2);
    chk(p1_pin_out, 8'hd4);
    wr(DPG_ADDR_P0_SKIP, 8'h81);
    wr(DPG_ADDR_P0_MATCH, 8'h5a);
    rd(DPG_ADDR_P0_MATCH, 1'b0, 8'h5a);
    chk(port_zero_crossbar_skip, 8'h81);
  endtask : t_bits

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  // Main sequence after five reset cycles
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    t_reset_vals();
    t_match();
    t_drive();
    t_analog();
    t_bits();
    complete_run();
  end

  // Watchdog: the scenarios need about 120 cycles
  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    complete_run();
  end
endmodule : dpg_gpio_tb
